// ### pkg/ssc_pkg.sv
// Constants and types shared by the spindle speed control block
package ssc_pkg;

	// ----------------------------------------------------------------
	// Bus geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 18;
	localparam int DATA_W = 32;
	localparam int BE_W   = 4;
	localparam int IDX_W  = 16;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_DAC  = 16'hE060;
	localparam logic [IDX_W-1:0] IDX_TGT  = 16'hE061;
	localparam logic [IDX_W-1:0] IDX_ERR  = 16'hE062;
	localparam logic [IDX_W-1:0] IDX_CTL  = 16'hE065;
	localparam logic [IDX_W-1:0] IDX_CNT  = 16'hE066;
	localparam logic [IDX_W-1:0] IDX_STAT = 16'hE068;
	localparam logic [IDX_W-1:0] IDX_MASK = 16'hE069;
	localparam logic [IDX_W-1:0] IDX_LIVE = 16'hE06A;

	// ----------------------------------------------------------------
	// Field widths and positions
	// ----------------------------------------------------------------
	localparam int DAC_W        = 8;
	localparam int PERIOD_W     = 16;
	localparam int CNT_W        = 8;
	localparam int CTL_W        = 5;
	localparam int CTL_SAT_BIT  = 4;
	localparam int CTL_EN_BIT   = 3;
	localparam int CTL_CLK_BIT  = 2;
	localparam int CTL_SRC_LSB  = 0;
	localparam int CTL_SRC_W    = 2;
	localparam int STAT_W       = 2;
	localparam int STAT_SPIN    = 0;
	localparam int STAT_OVF     = 1;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [DAC_W-1:0]    RST_DAC    = 8'h00;
	localparam logic [PERIOD_W-1:0] RST_PERIOD = 16'h0000;
	localparam logic [CNT_W-1:0]    RST_CNT    = 8'h00;
	localparam logic [CTL_W-1:0]    RST_CTL    = 5'h00;
	localparam logic [STAT_W-1:0]   RST_STAT   = 2'h0;

	// ----------------------------------------------------------------
	// Count clock divider (bus clock divided by eight)
	// ----------------------------------------------------------------
	localparam int               DIV_W    = 3;
	localparam logic [DIV_W-1:0] DIV_LAST = 3'h7;

	// Spin interrupt source selection
	typedef enum logic [CTL_SRC_W-1:0] {
		SSC_SRC_INDEX,
		SSC_SRC_CNT_WRAP,
		SSC_SRC_PERIOD_OVF,
		SSC_SRC_SLOW
	} ssc_src_t;

endpackage

// ### rtl/ssc_edge_sync.sv
// Two-stage pin synchroniser with registered rising-edge pulse
`timescale 1ns/100ps
module ssc_edge_sync (
	input  wire logic mclk_in,
	input  wire logic resetn_in,
	input  wire logic pin_in,
	output logic      rise_out
);

	logic meta_r;
	logic sync_r;
	logic prev_r;
	logic rise_r;

	// ----------------------------------------------------------------
	// Synchroniser and edge detect
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
			rise_r <= 1'b0;
		end else begin
			meta_r <= pin_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
			rise_r <= sync_r & ~prev_r;
		end
	end

	assign rise_out = rise_r;

endmodule

// ### rtl/ssc_spindle_ctrl.sv
// Spindle speed control unit: registers, period measurement, spin counter
//
// Summary of operation
// - Firmware-writable 16-bit desired rotation period register, bits 15:0.
// - Period counted between index events is captured into speed error register.
// - Control bit 4 makes the period count saturate instead of wrapping.
// - Spin counters advance only while control bit 3 is set.
// - Control bit 2 picks count clock: bus clock or bus clock divided by eight.
// - Control bits 1:0 choose the event that raises the spin interrupt.
// - Spin event count is 8 bits wide; upper bits read zero.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/100ps
module ssc_spindle_ctrl
	import ssc_pkg::*;
#(
	parameter int PERIOD_BITS = ssc_pkg::PERIOD_W
) (
	input  wire logic                        mclk_in,
	input  wire logic                        resetn_in,
	input  wire logic [ssc_pkg::ADDR_W-1:0]  avs_address_in,
	input  wire logic                        avs_read_in,
	input  wire logic                        avs_write_in,
	input  wire logic [ssc_pkg::DATA_W-1:0]  avs_writedata_in,
	input  wire logic [ssc_pkg::BE_W-1:0]    avs_byteenable_in,
	output logic      [ssc_pkg::DATA_W-1:0]  avs_readdata_out,
	output logic                             avs_waitrequest_out,
	input  wire logic                        index_in,
	input  wire logic                        spin_event_in,
	output logic      [ssc_pkg::DAC_W-1:0]   spindle_dac_out,
	output logic                             irq_out
);

	import ssc_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic                   ack_r;
	logic                   req;
	logic                   wr_en;
	logic                   rd_take;
	logic [IDX_W-1:0]       acc_idx;
	logic                   aligned;
	logic [DATA_W-1:0]      readdata_r;
	logic [DATA_W-1:0]      rd_mux;

	logic [DAC_W-1:0]       spindle_dac_value_r;
	logic [PERIOD_BITS-1:0] spindle_target_period_r;
	logic [PERIOD_BITS-1:0] spindle_speed_error_r;
	logic [CTL_W-1:0]       spindle_control_r;
	logic [CNT_W-1:0]       spin_event_counter_r;
	logic [STAT_W-1:0]      stat_r;
	logic [STAT_W-1:0]      mask_r;
	logic [PERIOD_BITS-1:0] period_cnt_r;
	logic [DIV_W-1:0]       div_r;

	logic                   index_rise;
	logic                   spin_rise;
	logic                   cnt_enable;
	logic                   sat_enable;
	logic                   count_clock_select;
	ssc_src_t               src_sel;
	logic                   count_tick;
	logic                   period_full;
	logic                   ev_index;
	logic                   ev_wrap;
	logic                   ev_ovf;
	logic                   ev_slow;
	logic                   spin_ev;
	logic [STAT_W-1:0]      stat_set;
	logic [STAT_W-1:0]      stat_clr;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	ssc_edge_sync u_index_sync (
		.mclk_in   (mclk_in),
		.resetn_in (resetn_in),
		.pin_in    (index_in),
		.rise_out  (index_rise)
	);

	ssc_edge_sync u_spin_sync (
		.mclk_in   (mclk_in),
		.resetn_in (resetn_in),
		.pin_in    (spin_event_in),
		.rise_out  (spin_rise)
	);

	// ----------------------------------------------------------------
	// Byte-lane merge for 16-bit registers
	// ----------------------------------------------------------------
	function automatic logic [15:0] merge16(
		input logic [15:0]       old_val,
		input logic [DATA_W-1:0] wd,
		input logic [BE_W-1:0]   be
	);
		logic [15:0] res;
		res = old_val;
		if (be[0]) begin
			res[7:0] = wd[7:0];
		end
		if (be[1]) begin
			res[15:8] = wd[15:8];
		end
		return res;
	endfunction

	// ----------------------------------------------------------------
	// Avalon-MM slave handshake
	// ----------------------------------------------------------------
	// One wait cycle: request seen, then answered on the next edge
	assign req                 = avs_read_in | avs_write_in;
	assign avs_waitrequest_out = req & ~ack_r;
	assign wr_en               = avs_write_in & ack_r;
	assign rd_take             = avs_read_in & ~ack_r;
	assign acc_idx             = avs_address_in[ADDR_W-1:2];
	assign aligned             = (avs_address_in[1:0] == 2'h0);

	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req & ~ack_r;
		end
	end

	// ----------------------------------------------------------------
	// Read multiplexer
	// ----------------------------------------------------------------
	always_comb begin
		rd_mux = '0;
		if (aligned) begin
			unique case (acc_idx)
				IDX_DAC:  rd_mux[DAC_W-1:0]       = spindle_dac_value_r;
				IDX_TGT:  rd_mux[PERIOD_BITS-1:0] = spindle_target_period_r;
				IDX_ERR:  rd_mux[PERIOD_BITS-1:0] = spindle_speed_error_r;
				IDX_CTL:  rd_mux[CTL_W-1:0]       = spindle_control_r;
				IDX_CNT:  rd_mux[CNT_W-1:0]       = spin_event_counter_r;
				IDX_STAT: rd_mux[STAT_W-1:0]      = stat_r;
				IDX_MASK: rd_mux[STAT_W-1:0]      = mask_r;
				IDX_LIVE: rd_mux[PERIOD_BITS-1:0] = period_cnt_r;
				default:  rd_mux = '0;
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			readdata_r <= '0;
		end else if (rd_take) begin
			readdata_r <= rd_mux;
		end
	end

	assign avs_readdata_out = readdata_r;

	// ----------------------------------------------------------------
	// Firmware-owned registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			spindle_dac_value_r <= RST_DAC;
		end else if (wr_en && aligned && acc_idx == IDX_DAC && avs_byteenable_in[0]) begin
			spindle_dac_value_r <= avs_writedata_in[DAC_W-1:0];
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			spindle_target_period_r <= RST_PERIOD;
		end else if (wr_en && aligned && acc_idx == IDX_TGT) begin
			spindle_target_period_r <= merge16(spindle_target_period_r, avs_writedata_in,
				avs_byteenable_in);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			spindle_control_r <= RST_CTL;
		end else if (wr_en && aligned && acc_idx == IDX_CTL && avs_byteenable_in[0]) begin
			spindle_control_r <= avs_writedata_in[CTL_W-1:0];
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			mask_r <= RST_STAT;
		end else if (wr_en && aligned && acc_idx == IDX_MASK && avs_byteenable_in[0]) begin
			mask_r <= avs_writedata_in[STAT_W-1:0];
		end
	end

	assign spindle_dac_out = spindle_dac_value_r;

	// ----------------------------------------------------------------
	// Control field decode
	// ----------------------------------------------------------------
	assign sat_enable         = spindle_control_r[CTL_SAT_BIT];
	assign cnt_enable         = spindle_control_r[CTL_EN_BIT];
	assign count_clock_select = spindle_control_r[CTL_CLK_BIT];
	assign src_sel            = ssc_src_t'(spindle_control_r[CTL_SRC_LSB +: CTL_SRC_W]);

	// ----------------------------------------------------------------
	// Count clock: bus clock or bus clock divided by eight
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			div_r <= '0;
		end else if (cnt_enable) begin
			div_r <= div_r + 3'h1;
		end else begin
			div_r <= '0;
		end
	end

	assign count_tick = cnt_enable & (~count_clock_select | (div_r == DIV_LAST));

	// ----------------------------------------------------------------
	// Period measurement between index events
	// ----------------------------------------------------------------
	assign period_full = (period_cnt_r == {PERIOD_BITS{1'b1}});

	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			period_cnt_r <= RST_PERIOD;
		end else if (!cnt_enable || index_rise) begin
			period_cnt_r <= RST_PERIOD;
		end else if (count_tick) begin
			if (period_full && sat_enable) begin
				period_cnt_r <= period_cnt_r;
			end else begin
				period_cnt_r <= period_cnt_r + 1'b1;
			end
		end
	end

	// Index capture wins over a firmware write in the same cycle
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			spindle_speed_error_r <= RST_PERIOD;
		end else if (ev_index) begin
			spindle_speed_error_r <= period_cnt_r;
		end else if (wr_en && aligned && acc_idx == IDX_ERR) begin
			spindle_speed_error_r <= merge16(spindle_speed_error_r, avs_writedata_in,
				avs_byteenable_in);
		end
	end

	// ----------------------------------------------------------------
	// Spin event counter
	// ----------------------------------------------------------------
	// Hardware count wins over a firmware write in the same cycle
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			spin_event_counter_r <= RST_CNT;
		end else if (cnt_enable && spin_rise) begin
			spin_event_counter_r <= spin_event_counter_r + 8'h01;
		end else if (wr_en && aligned && acc_idx == IDX_CNT && avs_byteenable_in[0]) begin
			spin_event_counter_r <= avs_writedata_in[CNT_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Events and spin interrupt source
	// ----------------------------------------------------------------
	assign ev_index = cnt_enable & index_rise;
	assign ev_wrap  = cnt_enable & spin_rise & (spin_event_counter_r == {CNT_W{1'b1}});
	assign ev_ovf   = count_tick & ~index_rise & period_full;
	assign ev_slow  = ev_index & (period_cnt_r > spindle_target_period_r);

	always_comb begin
		unique case (src_sel)
			SSC_SRC_INDEX:      spin_ev = ev_index;
			SSC_SRC_CNT_WRAP:   spin_ev = ev_wrap;
			SSC_SRC_PERIOD_OVF: spin_ev = ev_ovf;
			SSC_SRC_SLOW:       spin_ev = ev_slow;
		endcase
	end

	// ----------------------------------------------------------------
	// Sticky status, write one to clear, set wins
	// ----------------------------------------------------------------
	always_comb begin
		stat_set            = '0;
		stat_set[STAT_SPIN] = spin_ev;
		stat_set[STAT_OVF]  = ev_ovf;
		stat_clr            = '0;
		if (wr_en && aligned && acc_idx == IDX_STAT && avs_byteenable_in[0]) begin
			stat_clr = avs_writedata_in[STAT_W-1:0];
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			stat_r <= RST_STAT;
		end else begin
			stat_r <= (stat_r & ~stat_clr) | stat_set;
		end
	end

	assign irq_out = |(stat_r & mask_r);

endmodule

// ### verification/ssc_spindle_ctrl_chk.sv
// Port-level assertions for the spindle speed control block
`timescale 1ns/100ps
module ssc_spindle_ctrl_chk
	import ssc_pkg::*;
#(
	parameter int PERIOD_BITS = PERIOD_W
) (
	input wire logic              mclk_in,
	input wire logic              resetn_in,
	input wire logic [ADDR_W-1:0] avs_address_in,
	input wire logic              avs_read_in,
	input wire logic              avs_write_in,
	input wire logic [DATA_W-1:0] avs_writedata_in,
	input wire logic [BE_W-1:0]   avs_byteenable_in,
	input wire logic [DATA_W-1:0] avs_readdata_out,
	input wire logic              avs_waitrequest_out,
	input wire logic              index_in,
	input wire logic              spin_event_in,
	input wire logic [DAC_W-1:0]  spindle_dac_out,
	input wire logic              irq_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);
	wire logic        rdone = avs_read_in && !avs_waitrequest_out;
	wire logic        wdone = avs_write_in && !avs_waitrequest_out;
	wire logic [15:0] ix    = avs_address_in[17:2];
	logic      [15:0] tgt_r;

	// Last target period written, lane by lane
	always_ff @(posedge mclk_in) begin
		if (!resetn_in)
			tgt_r <= 16'h0000;
		else if (wdone && ix == IDX_TGT) begin
			if (avs_byteenable_in[0])
				tgt_r[7:0] <= avs_writedata_in[7:0];
			if (avs_byteenable_in[1])
				tgt_r[15:8] <= avs_writedata_in[15:8];
		end
	end

	one_wait_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out) else $error("bus answer late");
	idle_nowait_a: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
		else $error("wait raised while idle");
	dac_load_a: assert property (wdone && ix == IDX_DAC && avs_byteenable_in[0] |=>
		{24'h0, spindle_dac_out} == ($past(avs_writedata_in) & 32'hFF)) else $error("dac");
	cnt_upper_a: assert property (rdone && ix == IDX_CNT |-> avs_readdata_out[31:8] == 0)
		else $error("count upper bits");
	ctl_upper_a: assert property (rdone && ix == IDX_CTL |-> avs_readdata_out[31:5] == 0)
		else $error("control upper bits");
	refuse_zero_a: assert property (rdone && ix == 16'hE063 |-> avs_readdata_out == 0)
		else $error("unmapped read");
	read_hold_a: assert property (!avs_read_in |=> $stable(avs_readdata_out))
		else $error("read data moved");
	tgt_readback_a: assert property (rdone && ix == IDX_TGT |->
		avs_readdata_out == {16'h0, tgt_r}) else $error("target period");
endmodule

bind ssc_spindle_ctrl ssc_spindle_ctrl_chk #(.PERIOD_BITS(PERIOD_BITS)) u_chk (.mclk_in,
	.resetn_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
	.avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .index_in, .spin_event_in,
	.spindle_dac_out, .irq_out);

// ### verification/ssc_motor_model.sv
// Spindle motor model: drive value sets the rotation period
`timescale 1ns/100ps
module ssc_motor_model (
	input  wire logic       mclk_in,
	input  wire logic [7:0] dac_in,
	output logic            index_out,
	output logic            spin_out
);
	int ph = 0;
	int per;
	initial begin
		index_out = 1'b0;
		spin_out = 1'b0;
	end
	// Stopped motor at zero drive; four spin marks per turn
	always @(posedge mclk_in) begin
		per = 512 - 2 * int'(dac_in);
		// Shortest turn is 16 cycles; there the spin marks run together and spin stays high
		if (per < 16)
			per = 16;
		ph = (dac_in == 0) ? 0 : (ph + 1) % per;
		index_out <= (dac_in != 0) && (ph >= per - 4);
		spin_out <= (dac_in != 0) && (ph % (per / 4) >= per / 4 - 4);
	end
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the spindle speed control block
`timescale 1ns/100ps
module tb_top;
	import ssc_pkg::*;
	logic              mclk_in = 1'b0;
	logic              resetn_in = 1'b0;
	logic              rd = 1'b0;
	logic              wr = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] q;
	logic              waitreq;
	logic              irq;
	logic              idx;
	logic              spn;
	logic [DAC_W-1:0]  dac;
	int                fail_count = 0;
	int                n_compared = 0;
	int                spins = 0;
	int                per;
	int                a;
	int                mdl [7];
	logic [IDX_W-1:0]  ixs [7] = '{IDX_TGT, IDX_ERR, IDX_CTL, IDX_CNT, IDX_MASK, 16'hE063, IDX_DAC};
	int                ms [7] = '{32'hFFFF, 32'hFFFF, 32'h1F, 32'hFF, 32'h3, 0, 32'hFF};

	always #4 mclk_in = ~mclk_in;
	always @(posedge spn) spins++;

	ssc_spindle_ctrl u_ssc_spindle_ctrl (
		.mclk_in            (mclk_in),
		.resetn_in          (resetn_in),
		.avs_address_in     (addr),
		.avs_read_in        (rd),
		.avs_write_in       (wr),
		.avs_writedata_in   (wdata),
		.avs_byteenable_in  (4'h3),
		.avs_readdata_out   (rdata),
		.avs_waitrequest_out(waitreq),
		.index_in           (idx),
		.spin_event_in      (spn),
		.spindle_dac_out    (dac),
		.irq_out            (irq)
	);
	ssc_motor_model u_ssc_motor_model (.mclk_in(mclk_in), .dac_in(dac), .index_out(idx),
		.spin_out(spn));

	task automatic close_out();
		$display("compared %0d mismatched %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic near(input string nm, input int e, input int t, input logic [31:0] s);
		n_compared++;
		if ($isunknown(s) || s > e + t || s + t < e) begin
			fail_count++;
			$display("Error %s expected %0d seen %0d", nm, e, s);
		end
	endtask

	// Called just after a rising edge; returns one edge after the edge that samples waitrequest low
	task automatic bus(input logic w, input logic [IDX_W-1:0] ix, input logic [31:0] d);
		int n;
		n = 0;
		rd <= !w;
		wr <= w;
		addr <= {ix, 2'b00};
		wdata <= d;
		do begin
			@(posedge mclk_in);
			n++;
		end while (waitreq !== 1'b0 && n < 40);
		q = rdata;
		if (n >= 40)
			fail_count++;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge mclk_in);
	endtask

	initial begin
		repeat (90000) @(posedge mclk_in);
		fail_count++;
		close_out();
	end

	initial begin
		void'($urandom(32'hB7A74817));
		repeat (16) @(posedge mclk_in);
		resetn_in <= 1'b1;
		@(posedge mclk_in);
		for (int i = 0; i < 7; i++) begin
			// Spin counters stay off while the registers are checked
			bus(1'b1, ixs[i], $urandom() & ~((i == 2) ? 32'h8 : 32'h0));
			mdl[i] = wdata & ms[i];
		end
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, ixs[i], '0);
			cmp("reg", mdl[i], q);
		end
		cmp("dac", mdl[6], dac);
		for (int c = 0; c < 2; c++) begin
			bus(1'b1, IDX_CTL, 8 + 4 * c);
			bus(1'b1, IDX_DAC, 1 + $urandom() % 200);
			per = 512 - 2 * dac;
			repeat (3 * per) @(posedge mclk_in);
			bus(1'b0, IDX_ERR, '0);
			near("period", per / (c ? 8 : 1), 1, q);
		end
		bus(1'b1, IDX_CTL, 0);
		bus(1'b0, IDX_CNT, '0);
		a = q;
		repeat (per) @(posedge mclk_in);
		bus(1'b0, IDX_CNT, '0);
		cmp("hold", a, q);
		bus(1'b1, IDX_CTL, 8);
		bus(1'b1, IDX_CNT, 0);
		bus(1'b0, IDX_CNT, '0);
		a = spins - int'(q);
		repeat (per) @(posedge mclk_in);
		bus(1'b0, IDX_CNT, '0);
		near("count", spins - a, 1, q);
		bus(1'b1, IDX_TGT, 1);
		bus(1'b1, IDX_MASK, 1);
		for (int s = 0; s < 4; s++) begin
			bus(1'b1, IDX_CTL, s);
			bus(1'b1, IDX_STAT, 3);
			bus(1'b1, IDX_CNT, 32'hFE);
			bus(1'b1, IDX_CTL, 8 + s);
			repeat (2 * per) @(posedge mclk_in);
			bus(1'b0, IDX_STAT, '0);
			cmp("status", s != 2, q & 1);
			cmp("irq", s != 2, irq);
		end
		bus(1'b1, IDX_MASK, 0);
		cmp("masked", 0, irq);
		bus(1'b1, IDX_DAC, 0);
		bus(1'b1, IDX_CTL, 24);
		bus(1'b1, IDX_MASK, 2);
		bus(1'b1, IDX_STAT, 3);
		repeat (66000) @(posedge mclk_in);
		bus(1'b0, IDX_LIVE, '0);
		cmp("live", 32'hFFFF, q);
		cmp("ovf irq", 1, irq);
		bus(1'b1, IDX_CTL, 8);
		bus(1'b0, IDX_LIVE, '0);
		near("wrap", 2, 3, q);
		close_out();
	end
endmodule
